// *** core/pmcs_defines.vh ***
// Constants for the power-mode and clock supervisor
`ifndef PMCS_DEFINES_VH
`define PMCS_DEFINES_VH
`define PMCS_CLK_MHZ          25
`define PMCS_RST_PULSE_NS     20000
`define PMCS_RST_PULSE_CYC    ((`PMCS_RST_PULSE_NS * `PMCS_CLK_MHZ) / 1000)
`define PMCS_CSS_TIMEOUT_NS   2000
`define PMCS_CSS_TIMEOUT_CYC  ((`PMCS_CSS_TIMEOUT_NS * `PMCS_CLK_MHZ) / 1000)
`define PMCS_PIN_HOLDOFF      2'h3
// Register byte offsets
`define PMCS_OFS_CTRL         8'h00
`define PMCS_OFS_STATUS       8'h04
`define PMCS_OFS_INT_STAT     8'h08
`define PMCS_OFS_INT_EN       8'h0C
`define PMCS_OFS_INT_CLR      8'h10
// Control fields
`define PMCS_CTRL_DEEP        0
`define PMCS_CTRL_STANDBY     1
`define PMCS_CTRL_REG_LP      2
`define PMCS_CTRL_PLL_EXT     3
`define PMCS_CTRL_SEL_LO      4
`define PMCS_CTRL_SEL_HI      5
`define PMCS_CTRL_RST         7'h00
// Clock source encodings
`define PMCS_SEL_RC           2'h0
`define PMCS_SEL_EXT          2'h1
`define PMCS_SEL_PLL          2'h2
// Interrupt bits
`define PMCS_INT_EXT_FAIL     0
`define PMCS_INT_PLL_FAIL     1
`define PMCS_INT_STOP_WAKE    2
`define PMCS_INT_W            3
`endif

// *** core/pmcs_clk_monitor.v ***
// Clock presence monitor: flags a clock whose divided tick stops toggling
`timescale 1ns/100ps
module pmcs_clk_monitor #(
  parameter LIMIT = 50
) (
  input  wire core_clk,
  input  wire rst,
  input  wire enable,
  input  wire tick_async,
  output reg  fail_ff
);
  reg  [1:0]  sync_ff;
  reg         last_ff;
  reg  [15:0] cnt_ff;
  reg         dead_ff;
  wire        edge_seen = sync_ff[1] ^ last_ff;

  // Fail pulses once per loss; a fresh enable rearms the watch
  always @(posedge core_clk) begin
    if (rst) begin
      sync_ff <= 2'h0;
      last_ff <= 1'b0;
      cnt_ff  <= 16'h0000;
      dead_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[0], tick_async};
      last_ff <= sync_ff[1];
      fail_ff <= 1'b0;
      if (!enable || edge_seen) begin
        cnt_ff  <= 16'h0000;
        dead_ff <= 1'b0;
      end else if (!dead_ff) begin
        if (cnt_ff == LIMIT[15:0] - 16'h0001) begin
          fail_ff <= 1'b1;
          dead_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  end
endmodule

// *** core/pmcs_supervisor.v ***
// Power-mode and clock supervisor with APB register access
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "pmcs_defines.vh"
module pmcs_supervisor #(
  parameter RST_CYCLES  = `PMCS_RST_PULSE_CYC,
  parameter CSS_CYCLES  = `PMCS_CSS_TIMEOUT_CYC
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire        cpu_sleep_req,
  input  wire        periph_irq,
  input  wire [15:0] external_interrupt_lines,
  input  wire        supply_voltage_detector,
  input  wire        usart_wake,
  input  wire        i2c_wake,
  input  wire        cec_rx_wake,
  input  wire        usb_wake,
  input  wire        rtc_alarm,
  input  wire [1:0]  comp_out,
  input  wire        wake_pin,
  input  wire        independent_watchdog_rst,
  input  wire        reset_pin_n_i,
  output reg         reset_pin_n_o_ff,
  output reg         reset_pin_n_oe_ff,
  input  wire        ext_osc_tick,
  input  wire        pll_ref_tick,
  output reg         cpu_clk_en_ff,
  output reg         core_dom_clk_en_ff,
  output reg         core_dom_pwr_ff,
  output reg         core_rst_ff,
  output reg         regulator_on_ff,
  output reg         regulator_lp_ff,
  output reg         internal_fast_rc_osc_en_ff,
  output reg         external_fast_osc_en_ff,
  output reg         pll_en_ff,
  output reg  [1:0]  sys_clk_sel_ff,
  output reg         lowspeed_clk_en_ff,
  output reg         irq_ff
);
  localparam ST_RUN   = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_STOP  = 3'h2;
  localparam ST_STBY  = 3'h3;
  localparam ST_RSEQ  = 3'h4;
  localparam NSYNC    = 27;
  // Positions of the single-bit sources in the synchroniser vector
  localparam SY_WDG   = NSYNC - 1;
  localparam SY_PIN   = NSYNC - 2;
  localparam SY_WAKE  = NSYNC - 3;
  localparam SY_ALARM = NSYNC - 6;
  localparam NWAKE    = NSYNC - 3;

  // Every asynchronous source passes a two-stage synchroniser
  wire [NSYNC-1:0] async_in = {independent_watchdog_rst, reset_pin_n_i,
    wake_pin, comp_out, rtc_alarm, usb_wake, cec_rx_wake, i2c_wake,
    usart_wake, supply_voltage_detector, external_interrupt_lines};
  reg  [NSYNC-1:0] meta_ff;
  reg  [NSYNC-1:0] sync_ff;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge core_clk) begin
        if (rst) begin
          meta_ff[g] <= (g == SY_PIN) ? 1'b1 : 1'b0;
          sync_ff[g] <= (g == SY_PIN) ? 1'b1 : 1'b0;
        end else begin
          meta_ff[g] <= async_in[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  wire             wdg_rst_s  = sync_ff[SY_WDG];
  wire             pin_n_s    = sync_ff[SY_PIN];
  wire             wake_pin_s = sync_ff[SY_WAKE];
  wire             alarm_s    = sync_ff[SY_ALARM];
  wire [NWAKE-1:0] external_interrupt_lines_s     = sync_ff[NWAKE-1:0];

  reg  [2:0]  state_ff;
  reg  [15:0] rcnt_ff;
  reg  [1:0]  holdoff_ff;
  reg         wake_pin_d_ff;
  reg  [6:0]  ctrl_ff;
  reg  [`PMCS_INT_W-1:0] int_stat_ff;
  reg  [`PMCS_INT_W-1:0] int_en_ff;

  wire [1:0] sel = ctrl_ff[`PMCS_CTRL_SEL_HI:`PMCS_CTRL_SEL_LO];
  wire       up  = (state_ff == ST_RUN) || (state_ff == ST_SLEEP);
  wire       ext_fail;
  wire       pll_fail;

  // External pin is ignored while and just after we drive it ourselves
  wire pin_rst   = !pin_n_s && !reset_pin_n_oe_ff && holdoff_ff == 2'h0;
  wire reset_req = pin_rst || wdg_rst_s;
  // Comparators, CEC and all line sources reach the stop wake-up OR
  wire stop_wake = |external_interrupt_lines_s;
  wire stby_wake = (wake_pin_s && !wake_pin_d_ff) || alarm_s;
  wire ext_mon_en = up && sel == `PMCS_SEL_EXT;
  wire pll_mon_en = up && sel == `PMCS_SEL_PLL &&
                    ctrl_ff[`PMCS_CTRL_PLL_EXT];

  pmcs_clk_monitor #(.LIMIT(CSS_CYCLES)) u_ext_mon (
    .core_clk   (core_clk),
    .rst        (rst),
    .enable     (ext_mon_en),
    .tick_async (ext_osc_tick),
    .fail_ff    (ext_fail)
  );

  pmcs_clk_monitor #(.LIMIT(CSS_CYCLES)) u_pll_mon (
    .core_clk   (core_clk),
    .rst        (rst),
    .enable     (pll_mon_en),
    .tick_async (pll_ref_tick),
    .fail_ff    (pll_fail)
  );

  // APB decode
  wire       acc      = psel && penable;
  wire       wr_done  = acc && pready_ff && pwrite;
  wire [7:0] a        = paddr;
  wire       mapped   = a == `PMCS_OFS_CTRL || a == `PMCS_OFS_STATUS ||
                        a == `PMCS_OFS_INT_STAT || a == `PMCS_OFS_INT_EN ||
                        a == `PMCS_OFS_INT_CLR;
  reg  [31:0] rd_mux;
  always @* begin
    case (a)
      `PMCS_OFS_CTRL:     rd_mux = {25'h000_0000, ctrl_ff};
      `PMCS_OFS_STATUS:   rd_mux = {24'h00_0000, 1'b0, state_ff,
                                    2'h0, sys_clk_sel_ff};
      `PMCS_OFS_INT_STAT: rd_mux = {29'h0000_0000, int_stat_ff};
      `PMCS_OFS_INT_EN:   rd_mux = {29'h0000_0000, int_en_ff};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (acc && !pready_ff) begin
      pready_ff  <= 1'b1;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= !mapped;
    end else begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  // Software registers; clock fallback overrides the select field
  wire [`PMCS_INT_W-1:0] int_set = {
    state_ff == ST_STOP && stop_wake && !reset_req,
    pll_fail, ext_fail};
  wire [`PMCS_INT_W-1:0] int_clr =
    (wr_done && a == `PMCS_OFS_INT_CLR) ? pwdata[`PMCS_INT_W-1:0]
                                        : {`PMCS_INT_W{1'b0}};
  wire clk_to_rc = ext_fail || pll_fail ||
                   (state_ff == ST_STOP && stop_wake) ||
                   state_ff == ST_RSEQ;

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff     <= `PMCS_CTRL_RST;
      int_en_ff   <= {`PMCS_INT_W{1'b0}};
      int_stat_ff <= {`PMCS_INT_W{1'b0}};
    end else if (state_ff == ST_STBY) begin
      // Core domain is unpowered, so its registers do not survive standby
      ctrl_ff     <= `PMCS_CTRL_RST;
      int_en_ff   <= {`PMCS_INT_W{1'b0}};
      int_stat_ff <= {`PMCS_INT_W{1'b0}};
    end else begin
      if (wr_done && a == `PMCS_OFS_CTRL)
        ctrl_ff <= pwdata[6:0];
      if (clk_to_rc)
        ctrl_ff[`PMCS_CTRL_SEL_HI:`PMCS_CTRL_SEL_LO] <= `PMCS_SEL_RC;
      if (wr_done && a == `PMCS_OFS_INT_EN)
        int_en_ff <= pwdata[`PMCS_INT_W-1:0];
      // A new event wins over a clear in the same cycle
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
    end
  end

  // Mode sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      state_ff      <= ST_RSEQ;
      rcnt_ff       <= 16'h0000;
      holdoff_ff    <= 2'h0;
      wake_pin_d_ff <= 1'b0;
    end else begin
      wake_pin_d_ff <= wake_pin_s;
      if (reset_pin_n_oe_ff)
        holdoff_ff <= `PMCS_PIN_HOLDOFF;
      else if (holdoff_ff != 2'h0)
        holdoff_ff <= holdoff_ff - 2'h1;
      case (state_ff)
        ST_RUN: begin
          if (reset_req)
            state_ff <= ST_RSEQ;
          else if (cpu_sleep_req && !ctrl_ff[`PMCS_CTRL_DEEP])
            state_ff <= ST_SLEEP;
          else if (cpu_sleep_req && ctrl_ff[`PMCS_CTRL_STANDBY])
            state_ff <= ST_STBY;
          else if (cpu_sleep_req)
            state_ff <= ST_STOP;
        end
        ST_SLEEP: begin
          if (reset_req)
            state_ff <= ST_RSEQ;
          else if (periph_irq || stop_wake)
            state_ff <= ST_RUN;
        end
        ST_STOP: begin
          if (reset_req)
            state_ff <= ST_RSEQ;
          else if (stop_wake)
            state_ff <= ST_RUN;
        end
        ST_STBY: begin
          if (reset_req || stby_wake)
            state_ff <= ST_RSEQ;
        end
        ST_RSEQ: begin
          if (rcnt_ff == RST_CYCLES[15:0] - 16'h0001)
            state_ff <= ST_RUN;
        end
        default: state_ff <= ST_RSEQ;
      endcase
      if (state_ff == ST_RSEQ)
        rcnt_ff <= rcnt_ff + 16'h0001;
      else
        rcnt_ff <= 16'h0000;
    end
  end

  // Output stage, all registered
  always @(posedge core_clk) begin
    if (rst) begin
      cpu_clk_en_ff              <= 1'b0;
      core_dom_clk_en_ff         <= 1'b0;
      core_dom_pwr_ff            <= 1'b1;
      core_rst_ff                <= 1'b1;
      regulator_on_ff            <= 1'b1;
      regulator_lp_ff            <= 1'b0;
      internal_fast_rc_osc_en_ff <= 1'b1;
      external_fast_osc_en_ff    <= 1'b0;
      pll_en_ff                  <= 1'b0;
      sys_clk_sel_ff             <= `PMCS_SEL_RC;
      lowspeed_clk_en_ff         <= 1'b1;
      reset_pin_n_o_ff           <= 1'b0;
      reset_pin_n_oe_ff          <= 1'b1;
      irq_ff                     <= 1'b0;
    end else begin
      cpu_clk_en_ff      <= state_ff == ST_RUN;
      core_dom_clk_en_ff <= up;
      core_dom_pwr_ff    <= state_ff != ST_STBY;
      regulator_on_ff    <= state_ff != ST_STBY;
      regulator_lp_ff    <= state_ff == ST_STOP &&
                            ctrl_ff[`PMCS_CTRL_REG_LP];
      core_rst_ff        <= state_ff == ST_RSEQ;
      // Oscillators and PLL are off in stop and standby
      internal_fast_rc_osc_en_ff <= up || state_ff == ST_RSEQ;
      external_fast_osc_en_ff    <= up && (sel == `PMCS_SEL_EXT ||
        (sel == `PMCS_SEL_PLL && ctrl_ff[`PMCS_CTRL_PLL_EXT]));
      pll_en_ff          <= up && sel == `PMCS_SEL_PLL;
      sys_clk_sel_ff     <= clk_to_rc ? `PMCS_SEL_RC : sel;
      lowspeed_clk_en_ff <= 1'b1;
      reset_pin_n_o_ff   <= 1'b0;
      reset_pin_n_oe_ff  <= state_ff == ST_RSEQ;
      irq_ff <= |(((int_stat_ff & ~int_clr) | int_set) & int_en_ff);
    end
  end
endmodule

// *** test/pmcs_supervisor_checker.sv ***
// Port-level assertions for the power-mode and clock supervisor
`timescale 1ns/100ps
module pmcs_supervisor_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        periph_irq,
  input wire logic        wake_pin,
  input wire logic [15:0] external_interrupt_lines,
  input wire logic        pready_ff,
  input wire logic        cpu_clk_en_ff,
  input wire logic        core_dom_clk_en_ff,
  input wire logic        core_dom_pwr_ff,
  input wire logic        core_rst_ff,
  input wire logic        regulator_on_ff,
  input wire logic        regulator_lp_ff,
  input wire logic        internal_fast_rc_osc_en_ff,
  input wire logic        external_fast_osc_en_ff,
  input wire logic        pll_en_ff,
  input wire logic [1:0]  sys_clk_sel_ff,
  input wire logic        lowspeed_clk_en_ff,
  input wire logic        reset_pin_n_o_ff,
  input wire logic        reset_pin_n_oe_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_sleep;
    core_dom_clk_en_ff && !cpu_clk_en_ff && !core_rst_ff;
  endsequence
  sequence s_stop;
    core_dom_pwr_ff && !core_dom_clk_en_ff && !core_rst_ff;
  endsequence
  sequence s_standby;
    !core_dom_pwr_ff;
  endsequence
  a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
    else $error("pready held longer than one cycle");
  a_sleep_irq_wake: assert property (
    s_sleep ##0 periph_irq |-> ##[1:4] cpu_clk_en_ff)
    else $error("sleep not left on peripheral interrupt");
  a_stop_osc_off: assert property (s_stop |-> !pll_en_ff &&
    !external_fast_osc_en_ff && !internal_fast_rc_osc_en_ff)
    else $error("oscillator running in stop");
  a_lp_only_stop: assert property (
    regulator_lp_ff |-> !core_dom_clk_en_ff && regulator_on_ff)
    else $error("low-power regulator outside stop");
  a_stop_line_wake: assert property (
    s_stop ##0 (|external_interrupt_lines) |-> ##[1:8] cpu_clk_en_ff)
    else $error("stop not left on external line");
  a_standby_off: assert property (s_standby |-> !regulator_on_ff &&
    !pll_en_ff && !external_fast_osc_en_ff && !internal_fast_rc_osc_en_ff)
    else $error("supply or oscillator on in standby");
  a_standby_pin_exit: assert property (
    s_standby ##0 $rose(wake_pin) |-> ##[1:8] core_rst_ff)
    else $error("standby not left on wake pin rise");
  a_lowspeed_on: assert property (lowspeed_clk_en_ff)
    else $error("low-speed clock stopped");
  a_rc_after_reset: assert property (
    $fell(core_rst_ff) |-> sys_clk_sel_ff == 2'h0)
    else $error("clock not on internal RC after reset");
  a_pin_driven_low: assert property (core_rst_ff |->
    reset_pin_n_oe_ff && !reset_pin_n_o_ff)
    else $error("reset pin not driven low in reset");
  a_stop_wake_rc: assert property (
    s_stop ##1 core_dom_clk_en_ff |-> ##[0:1] sys_clk_sel_ff == 2'h0)
    else $error("stop wake not on internal RC");
  a_standby_full_rst: assert property (
    $rose(core_dom_pwr_ff) |-> core_rst_ff)
    else $error("standby exit without reset sequence");
endmodule

// *** test/pmcs_osc_model.sv ***
// Oscillator tick model; each tick stops while its run input is low
`timescale 1ns/100ps
module pmcs_osc_model (
  input  wire logic ext_run,
  input  wire logic pll_run,
  output logic      ext_osc_tick,
  output logic      pll_ref_tick
);
  initial begin
    ext_osc_tick = 1'b0;
    pll_ref_tick = 1'b0;
  end
  // Own timebase, unrelated in phase to the core clock
  // Ticks stand for prescaled clocks kept inside the bus limits
  always #57 if (ext_run) ext_osc_tick = ~ext_osc_tick;
  always #71 if (pll_run) pll_ref_tick = ~pll_ref_tick;
endmodule

// *** test/pmcs_supervisor_tb_top.sv ***
// Self-checking bench for the power-mode and clock supervisor
`timescale 1ns/100ps
`include "pmcs_defines.vh"
module pmcs_supervisor_tb_top;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic        er, cpu_sleep_req = 0, periph_irq = 0, ext_run = 1;
  logic        pll_run = 1;
  logic [23:0] wk = 0;
  logic [3:0]  sb = 0;
  int          fails = 0, checked = 0, cyc = 0;
  wire [31:0]  prdata_ff;
  wire [15:0]  external_interrupt_lines;
  wire [1:0]   comp_out, sys_clk_sel_ff;
  wire pready_ff, pslverr_ff, supply_voltage_detector, usart_wake, i2c_wake;
  wire cec_rx_wake, usb_wake, reset_pin_n_o_ff, reset_pin_n_oe_ff;
  wire ext_osc_tick, pll_ref_tick, cpu_clk_en_ff, core_dom_clk_en_ff;
  wire core_dom_pwr_ff, core_rst_ff, regulator_on_ff, regulator_lp_ff;
  wire internal_fast_rc_osc_en_ff, external_fast_osc_en_ff, pll_en_ff;
  wire lowspeed_clk_en_ff, irq_ff;
  wire rtc_alarm = wk[23] | sb[3];
  wire independent_watchdog_rst = sb[1];
  wire wake_pin = sb[2];
  // Pin has a pull-up: high unless someone drives it low
  wire reset_pin_n_i = reset_pin_n_oe_ff ? reset_pin_n_o_ff : !sb[0];
  assign {comp_out, usb_wake, cec_rx_wake, i2c_wake, usart_wake,
          supply_voltage_detector, external_interrupt_lines} = wk[22:0];
  pmcs_supervisor #(.RST_CYCLES(8), .CSS_CYCLES(8)) dut (.*);
  pmcs_osc_model osc (.*);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 0;
    penable <= 0;
  endtask
  task run_wait;
    for (int i = 0; i < 60 && cpu_clk_en_ff !== 1'b1; i++)
      @(posedge core_clk);
  endtask
  task nap;
    @(posedge core_clk) cpu_sleep_req <= 1;
    @(posedge core_clk) cpu_sleep_req <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  task fail_wait;
    for (int i = 0; i < 60 && sys_clk_sel_ff !== 2'h0; i++)
      @(posedge core_clk);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    repeat (2) @(posedge core_clk);
    chk({core_rst_ff, reset_pin_n_oe_ff}, 2'h3);
    run_wait;
    apb(0, `PMCS_OFS_STATUS, 0); chk(rd, 0);
    apb(0, 8'hFC, 0); chk(rd, 0);
    chk(er, 1);
    apb(1, `PMCS_OFS_CTRL, 8'h4C); apb(0, `PMCS_OFS_CTRL, 0);
    chk(rd, 8'h4C);
    $display("test registers done");
    apb(1, `PMCS_OFS_CTRL, 0); nap;
    chk({cpu_clk_en_ff, core_dom_clk_en_ff}, 2'h1);
    periph_irq <= 1; run_wait; chk(cpu_clk_en_ff, 1);
    periph_irq <= 0;
    $display("test sleep done");
    apb(1, `PMCS_OFS_CTRL, 8'h15);
    for (int i = 0; i < 24; i++) begin
      nap;
      chk({core_dom_clk_en_ff, pll_en_ff, external_fast_osc_en_ff,
           internal_fast_rc_osc_en_ff, regulator_lp_ff, regulator_on_ff,
           lowspeed_clk_en_ff}, 7'h07);
      wk <= 24'h1 << i; run_wait; chk(cpu_clk_en_ff, 1);
      chk(sys_clk_sel_ff, 0);
      wk <= 0;
    end
    apb(0, `PMCS_OFS_INT_STAT, 0); chk(rd, 4);
    apb(1, `PMCS_OFS_INT_CLR, 4); apb(0, `PMCS_OFS_INT_STAT, 0); chk(rd, 0);
    $display("test stop done");
    apb(1, `PMCS_OFS_INT_EN, 2); apb(1, `PMCS_OFS_CTRL, 8'h10);
    repeat (4) @(posedge core_clk); chk(sys_clk_sel_ff, 1);
    ext_run <= 0; fail_wait; chk(sys_clk_sel_ff, 0);
    chk(irq_ff, 0);
    apb(0, `PMCS_OFS_INT_STAT, 0); chk(rd, 1);
    ext_run <= 1; apb(1, `PMCS_OFS_CTRL, 8'h28);
    repeat (4) @(posedge core_clk); chk(sys_clk_sel_ff, 2);
    pll_run <= 0; fail_wait; chk({sys_clk_sel_ff, irq_ff}, 3'h1);
    apb(0, `PMCS_OFS_INT_STAT, 0); chk(rd, 3);
    apb(1, `PMCS_OFS_INT_CLR, 3); repeat (2) @(posedge core_clk);
    chk(irq_ff, 0);
    pll_run <= 1;
    $display("test clock fail done");
    for (int j = 0; j < 4; j++) begin
      apb(1, `PMCS_OFS_CTRL, 8'h43); nap;
      chk({core_dom_pwr_ff, regulator_on_ff, internal_fast_rc_osc_en_ff,
           pll_en_ff, lowspeed_clk_en_ff}, 5'h01);
      sb <= 4'h1 << j;
      for (int i = 0; i < 40 && core_rst_ff !== 1'b1; i++)
        @(posedge core_clk);
      chk(core_rst_ff, 1);
      sb <= 0; run_wait;
      apb(0, `PMCS_OFS_CTRL, 0); chk(rd, 0);
      apb(0, `PMCS_OFS_INT_EN, 0); chk(rd, 0);
    end
    $display("test standby done");
    give_verdict;
  end
endmodule
bind pmcs_supervisor pmcs_supervisor_checker chk_u (.*);
